// >>> include/afl_map.svh
// constants for the admin feature and log query block
`ifndef AFL_MAP_SVH
`define AFL_MAP_SVH
// ==========================================================
// command dword 10 fields
`define AFL_FSEL_HI 7
`define AFL_FSEL_LO 0
`define AFL_DWORD_COUNT_HI 27
`define AFL_DWORD_COUNT_LO 16
`define AFL_LSEL_HI 15
`define AFL_LSEL_LO 0
// ==========================================================
// feature selectors
`define AFL_FEAT_FIRST 8'h01
`define AFL_FEAT_LAST 8'h0B
`define AFL_FEAT_LBA 8'h03
`define AFL_FEAT_MARK 8'h80
// ==========================================================
// log selectors
`define AFL_LOG_ERR 16'h0001
`define AFL_LOG_HEALTH 16'h0002
`define AFL_LOG_SLOT 16'h0003
`define AFL_LOG_VEND_LO 16'h0080
`define AFL_LOG_VEND_HI 16'h00FF
// ==========================================================
// buffer geometry and entry layout (dwords)
`define AFL_PAGE_BYTES 13'h1000
`define AFL_DW_BYTES 13'h0004
`define AFL_ENT_DW 5'h10
`define AFL_ENT_USED_DW 4'h8
`define AFL_CNT_START 64'h0000_0000_0000_0001
`define AFL_PLOC_BYTE_W 8
`define AFL_PLOC_BIT_W 3
`define AFL_IDX_W 12
`endif

// >>> include/afl_pkg.sv
// types for the admin feature and log query block
package afl_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_CPL} state_t;
	typedef struct packed {
		state_t st;
		logic is_log;
		logic [15:0] sel;
		logic [11:0] remain;
		logic [11:0] idx;
		logic [63:0] first_buffer_pointer;
		logic [63:0] second_buffer_pointer;
		logic wr_valid;
		logic [63:0] wr_addr;
		logic [31:0] wr_data;
		logic [11:0] wr_idx;
		logic cpl_valid;
		logic [31:0] cpl_dw0;
		logic [15:0] cpl_status;
		logic persist;
		logic [63:0] err_count;
		logic [7:0] head;
		logic [8:0] n_valid;
	} state_s_t;
endpackage : afl_pkg

// >>> core/admin_feature_log_query.sv
// command engine for the feature query and log page query admin commands
// Behaviour
// [R1] feature query reads only both buffer pointers and dword 10
// [R2] feature selector is dword 10 bits 7:0, upper bits ignored
// [R3] selectors 01h..0Bh and 80h are known features
// [R4] only 03h returns a data buffer; 03h and 80h persist across power states
// [R5] host gives 4KB buffer, one discontinuity; no structure means pointers ignored
// [R6] second pointer only addresses the part after the page break
// [R7] after attributes are returned a completion is posted, dword 0 carries info
// [R8] log query reads only both buffer pointers and dword 10
// [R9] host gives 4KB log buffer; device writes the page into it
// [R10] dword count is bits 27:16, log selector bits 15:0, top bits ignored
// [R11] logs 01h..03h supported, 00h and 04h..7Fh reserved, 80h..FFh vendor
// [R12] one device-wide error log, fed by errored completions and error events
// [R13] n requested entries give the newest n errors, newest first
// [R14] each entry is 64 bytes; entry count reported as a parameter
// [R15] 64-bit error count starts at 1, increments, restorable; 0 marks empty
// [R16] entry holds queue id, command id and status code
// [R17] parameter location: byte in bits 7:0, bit in bits 10:8
// [R18] entry holds first failing block address and namespace
// [R19] byte 28 holds vendor log selector or 00h
// [R20] host asks for device-wide health log with namespace all ones
// [R21] reserved entry bytes and unused structure space return zero
//
// Our own choices: the plain strobed port.
`include "afl_map.svh"
`timescale 1ns/100ps
`default_nettype none
module admin_feature_log_query #(
	parameter int ERR_DEPTH = 4,
	parameter int FEAT_BUF_DW = 1024,
	parameter logic [15:0] ST_OK = 16'h0000,
	parameter logic [15:0] ST_BAD_FIELD = 16'h0002,
	parameter logic [15:0] ST_BAD_LOG = 16'h0009
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_is_log,
	input wire logic [63:0] i_first_buffer_pointer,
	input wire logic [63:0] i_second_buffer_pointer,
	input wire logic [31:0] i_cdw10,
	output logic o_cmd_ready,
	output logic [7:0] o_feature_selector,
	input wire logic [31:0] i_feat_attr,
	output logic [15:0] o_log_selector,
	output logic [11:0] o_src_idx,
	input wire logic [31:0] i_src_data,
	output logic o_wr_valid,
	output logic [63:0] o_wr_addr,
	output logic [31:0] o_wr_data,
	input wire logic i_wr_ready,
	output logic o_cpl_valid,
	output logic [31:0] o_cpl_dw0,
	output logic [15:0] o_cpl_status,
	output logic o_feat_persist,
	input wire logic i_err_valid,
	input wire logic [15:0] i_err_sqid,
	input wire logic [15:0] i_err_cid,
	input wire logic [15:0] i_err_status,
	input wire logic [7:0] i_err_byte,
	input wire logic [2:0] i_err_bit,
	input wire logic [63:0] i_err_lba,
	input wire logic [31:0] i_err_nsid,
	input wire logic [7:0] i_err_vend_log,
	input wire logic i_cnt_restore,
	input wire logic [63:0] i_cnt_restore_val,
	output logic [63:0] o_err_count,
	output logic [15:0] o_err_entries
);
	localparam int AW = $clog2(ERR_DEPTH);
	typedef struct packed {
		logic [63:0] cnt;
		logic [15:0] sqid;
		logic [15:0] cid;
		logic [15:0] status;
		logic [15:0] ploc;
		logic [63:0] lba;
		logic [31:0] nsid;
		logic [7:0] vend;
	} err_ent_t;

	afl_pkg::state_s_t q, d;
	err_ent_t mem [ERR_DEPTH];
	err_ent_t ent;
	logic [11:0] ent_no, ent_dw;
	logic [AW-1:0] slot;
	logic [31:0] log_dw, src_dw;
	logic [12:0] page_off;
	logic [23:0] span;
	logic fsel_known, lsel_ok, uses_buf;

	// ==========================================================
	// error log storage
	// [R12] single shared log
	always_ff @(posedge i_clk) begin
		if (i_err_valid) begin
			mem[q.head[AW-1:0]] <= '{cnt: q.err_count,
				sqid: i_err_sqid, cid: i_err_cid, status: i_err_status,
				// [R17] byte and bit location
				ploc: {5'h00, i_err_bit, i_err_byte},
				lba: i_err_lba, nsid: i_err_nsid, vend: i_err_vend_log};
		end
	end

	// ==========================================================
	// decode and data selection
	always_comb begin
		// [R2] only low byte is the selector
		fsel_known = (i_cdw10[`AFL_FSEL_HI:`AFL_FSEL_LO] >= `AFL_FEAT_FIRST &&
			i_cdw10[`AFL_FSEL_HI:`AFL_FSEL_LO] <= `AFL_FEAT_LAST) ||
			i_cdw10[`AFL_FSEL_HI:`AFL_FSEL_LO] == `AFL_FEAT_MARK;
		// [R11] mandatory and vendor pages accepted
		lsel_ok = (i_cdw10[`AFL_LSEL_HI:`AFL_LSEL_LO] >= `AFL_LOG_ERR &&
			i_cdw10[`AFL_LSEL_HI:`AFL_LSEL_LO] <= `AFL_LOG_SLOT) ||
			(i_cdw10[`AFL_LSEL_HI:`AFL_LSEL_LO] >= `AFL_LOG_VEND_LO &&
			i_cdw10[`AFL_LSEL_HI:`AFL_LSEL_LO] <= `AFL_LOG_VEND_HI);
		// [R4] only the range-type feature has a buffer
		uses_buf = i_cdw10[`AFL_FSEL_HI:`AFL_FSEL_LO] == `AFL_FEAT_LBA;
		ent_no = q.idx >> 4;
		ent_dw = q.idx & 12'(`AFL_ENT_DW - 5'h01);
		// [R13] newest first: walk back from the write slot
		slot = AW'(q.head[AW-1:0] - AW'(1) - ent_no[AW-1:0]);
		ent = mem[slot];
		log_dw = 32'h0000_0000;
		case (ent_dw[3:0])
			// [R15] count in the first two dwords
			4'h0: log_dw = ent.cnt[31:0];
			4'h1: log_dw = ent.cnt[63:32];
			// [R16] queue, command and status
			4'h2: log_dw = {ent.cid, ent.sqid};
			4'h3: log_dw = {ent.ploc, ent.status};
			// [R18] block address and namespace
			4'h4: log_dw = ent.lba[31:0];
			4'h5: log_dw = ent.lba[63:32];
			4'h6: log_dw = ent.nsid;
			// [R19] vendor page pointer, upper bytes zero
			4'h7: log_dw = {24'h00_0000, ent.vend};
			default: log_dw = 32'h0000_0000;
		endcase
		// [R21] slots past the stored errors read as empty
		if ({3'h0, ent_no} >= {4'h0, q.n_valid} || ent_no >= 12'(ERR_DEPTH)) begin
			log_dw = 32'h0000_0000;
		end
		if (q.is_log && q.sel == `AFL_LOG_ERR) begin
			src_dw = log_dw;
		end else begin
			src_dw = i_src_data;
		end
		// [R6] second pointer covers only the part past the page end
		page_off = {1'b0, q.first_buffer_pointer[11:0]};
		span = {11'h000, page_off} + {10'h000, q.idx, 2'b00};
	end

	// ==========================================================
	// command state machine
	always_comb begin
		d = q;
		d.cpl_valid = 1'b0;
		case (q.st)
			afl_pkg::ST_IDLE: begin
				// [R1] [R8] only pointers and dword 10 are taken
				if (i_cmd_valid) begin
					d.is_log = i_cmd_is_log;
					d.first_buffer_pointer = i_first_buffer_pointer;
					d.second_buffer_pointer = i_second_buffer_pointer;
					d.idx = 12'h000;
					d.cpl_dw0 = 32'h0000_0000;
					d.cpl_status = ST_OK;
					d.persist = 1'b0;
					d.st = afl_pkg::ST_XFER;
					if (i_cmd_is_log) begin
						// [R10] count and selector fields
						d.sel = i_cdw10[`AFL_LSEL_HI:`AFL_LSEL_LO];
						d.remain = i_cdw10[`AFL_DWORD_COUNT_HI:`AFL_DWORD_COUNT_LO];
						if (!lsel_ok) begin
							d.remain = 12'h000;
							d.cpl_status = ST_BAD_LOG;
						end
					end else begin
						d.sel = {8'h00, i_cdw10[`AFL_FSEL_HI:`AFL_FSEL_LO]};
						// [R5] pointers unused unless a structure returns
						d.remain = uses_buf ? 12'(FEAT_BUF_DW) : 12'h000;
						// [R3] unknown selectors are rejected
						if (!fsel_known) begin
							d.remain = 12'h000;
							d.cpl_status = ST_BAD_FIELD;
						end
						// [R4] persistent features
						d.persist = i_cdw10[`AFL_FSEL_HI:`AFL_FSEL_LO] == `AFL_FEAT_LBA ||
							i_cdw10[`AFL_FSEL_HI:`AFL_FSEL_LO] == `AFL_FEAT_MARK;
					end
				end
			end
			afl_pkg::ST_XFER: begin
				if (q.wr_valid && i_wr_ready) begin
					d.wr_valid = 1'b0;
				end
				// [R9] write one dword per free slot of the output stage
				if (!q.wr_valid || i_wr_ready) begin
					if (q.remain != 12'h000) begin
						d.wr_valid = 1'b1;
						d.wr_data = src_dw;
						d.wr_idx = q.idx;
						if (span >= {11'h000, `AFL_PAGE_BYTES}) begin
							d.wr_addr = q.second_buffer_pointer + 64'(span - {11'h000, `AFL_PAGE_BYTES});
						end else begin
							d.wr_addr = q.first_buffer_pointer + 64'({q.idx, 2'b00});
						end
						d.idx = q.idx + 12'h001;
						d.remain = q.remain - 12'h001;
					end else begin
						d.st = afl_pkg::ST_CPL;
					end
				end
			end
			afl_pkg::ST_CPL: begin
				// [R7] completion only after all data left
				d.cpl_valid = 1'b1;
				if (!q.is_log && q.cpl_status == ST_OK) begin
					d.cpl_dw0 = i_feat_attr;
				end
				d.st = afl_pkg::ST_IDLE;
			end
			default: d.st = afl_pkg::ST_IDLE;
		endcase
		// [R15] count starts at one and survives through restore
		if (i_cnt_restore) begin
			d.err_count = i_cnt_restore_val;
		end
		// [R12] capture wins over a simultaneous restore
		if (i_err_valid) begin
			d.err_count = q.err_count + 64'h0000_0000_0000_0001;
			d.head = q.head + 8'h01;
			if (q.n_valid < 9'(ERR_DEPTH)) begin
				d.n_valid = q.n_valid + 9'h001;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			q <= '0;
			q.st <= afl_pkg::ST_IDLE;
			q.err_count <= `AFL_CNT_START;
		end else begin
			q <= d;
		end
	end

	assign o_cmd_ready = q.st == afl_pkg::ST_IDLE;
	assign o_feature_selector = q.sel[7:0];
	assign o_log_selector = q.sel;
	assign o_src_idx = q.idx;
	assign o_wr_valid = q.wr_valid;
	assign o_wr_addr = q.wr_addr;
	assign o_wr_data = q.wr_data;
	assign o_cpl_valid = q.cpl_valid;
	assign o_cpl_dw0 = q.cpl_dw0;
	assign o_cpl_status = q.cpl_status;
	assign o_feat_persist = q.persist;
	assign o_err_count = q.err_count;
	// [R14] entry capacity reported for the identify structure
	assign o_err_entries = 16'(ERR_DEPTH);

	// ==========================================================
	// checks
	logic accept;
	assign accept = i_cmd_valid && q.st == afl_pkg::ST_IDLE;

	sequence drain_s;
		q.st == afl_pkg::ST_XFER ##1 q.st == afl_pkg::ST_CPL;
	endsequence
	sequence cpl_s;
		##1 o_cpl_valid;
	endsequence

	cpl_order_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
		drain_s |-> cpl_s)
		else $error("completion not posted after transfer");
	fsel_take_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
		accept && !i_cmd_is_log |=> q.sel == {8'h00, $past(i_cdw10[7:0])})
		else $error("feature selector misdecoded");
	dword_count_take_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
		accept && i_cmd_is_log && lsel_ok |=> q.remain == $past(i_cdw10[27:16]))
		else $error("dword count misdecoded");
	bad_log_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
		accept && i_cmd_is_log && !lsel_ok |-> ##3 (o_cpl_valid && o_cpl_status == ST_BAD_LOG))
		else $error("reserved log not rejected");
	no_buf_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R5]
		o_wr_valid |-> (q.is_log || q.sel == {8'h00, `AFL_FEAT_LBA}))
		else $error("buffer written for feature without data");
	page_ptr_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
		o_wr_valid |-> (o_wr_addr[63:12] == q.first_buffer_pointer[63:12] ||
			o_wr_addr[63:12] == q.second_buffer_pointer[63:12]))
		else $error("write outside both buffer pages");
	cnt_step_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
		i_err_valid |=> o_err_count == $past(o_err_count) + 64'h0000_0000_0000_0001)
		else $error("error count did not step");
	resv_zero_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R21]
		o_wr_valid && q.is_log && q.sel == `AFL_LOG_ERR && q.wr_idx[3] |-> o_wr_data == '0)
		else $error("reserved entry bytes not zero");
	persist_flag_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
		o_cpl_valid && !q.is_log |-> o_feat_persist ==
			(q.sel[7:0] == `AFL_FEAT_LBA || q.sel[7:0] == `AFL_FEAT_MARK))
		else $error("persistence flag wrong");
endmodule : admin_feature_log_query
`default_nettype wire

// >>> sim/host_buf_model.sv
// host buffer model: takes dword writes, stalls on request
`timescale 1ns/100ps
`default_nettype none
module host_buf_model (
	input wire logic i_clk,
	input wire logic i_slow,
	input wire logic i_wr_valid,
	input wire logic [63:0] i_wr_addr,
	input wire logic [31:0] i_wr_data,
	output logic o_wr_ready
);
	logic [63:0] wa[$];
	logic [31:0] wd[$];
	logic rdy_q = 1'b0;
	assign o_wr_ready = rdy_q;
	always @(posedge i_clk) begin
		rdy_q <= i_slow ? ~rdy_q : 1'b1;
		if (i_wr_valid && rdy_q) begin
			wa.push_back(i_wr_addr);
			wd.push_back(i_wr_data);
		end
	end
endmodule : host_buf_model
`default_nettype wire

// >>> sim/admin_feature_log_query_tb_top.sv
// self-checking bench for the feature and log query engine
`timescale 1ns/100ps
`default_nettype none
module admin_feature_log_query_tb_top;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic cv = 1'b0, il = 1'b0, ev = 1'b0, rs = 1'b0, slow = 1'b0;
	logic [63:0] p1 = '0, p2 = '0, lba = '0, rv = '0;
	logic [31:0] c10 = '0, ns = '0;
	logic [15:0] sq = '0, ci = '0, sc = '0;
	logic [7:0] eb = '0, vl = '0;
	logic [2:0] eo = '0;
	logic rdy, crdy, wv, cpl, pers;
	logic [7:0] fsel;
	logic [15:0] lsel, cst, nent;
	logic [11:0] sidx;
	logic [63:0] wad, ecnt;
	logic [31:0] wdt, dw0;
	int err_total = 0;
	int total_checks = 0;
	always #20 i_clk = ~i_clk;
	admin_feature_log_query #(.FEAT_BUF_DW(8)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_cmd_valid(cv), .i_cmd_is_log(il), .i_first_buffer_pointer(p1),
		.i_second_buffer_pointer(p2), .i_cdw10(c10), .o_cmd_ready(crdy),
		.o_feature_selector(fsel), .i_feat_attr(32'h1000_0000 | {24'h0, fsel}),
		.o_log_selector(lsel), .o_src_idx(sidx),
		.i_src_data(32'hA5A5_0000 | {20'h0, sidx}), .o_wr_valid(wv), .o_wr_addr(wad),
		.o_wr_data(wdt), .i_wr_ready(rdy), .o_cpl_valid(cpl), .o_cpl_dw0(dw0),
		.o_cpl_status(cst), .o_feat_persist(pers), .i_err_valid(ev), .i_err_sqid(sq),
		.i_err_cid(ci), .i_err_status(sc), .i_err_byte(eb), .i_err_bit(eo),
		.i_err_lba(lba), .i_err_nsid(ns), .i_err_vend_log(vl), .i_cnt_restore(rs),
		.i_cnt_restore_val(rv), .o_err_count(ecnt), .o_err_entries(nent));
	host_buf_model u_host (.i_clk(i_clk), .i_slow(slow), .i_wr_valid(wv),
		.i_wr_addr(wad), .i_wr_data(wdt), .o_wr_ready(rdy));
	// ==========================================
	// helpers
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic tick;
		@(posedge i_clk);
		#1;
	endtask : tick
	// bounded wait for the completion pulse
	task automatic run(input logic lg, input logic [31:0] d10);
		int k;
		u_host.wa.delete();
		u_host.wd.delete();
		@(posedge i_clk);
		il <= lg;
		c10 <= d10;
		cv <= 1'b1;
		@(posedge i_clk);
		cv <= 1'b0;
		for (k = 0; k < 3000 && cpl !== 1'b1; k++)
			tick();
		if (k == 3000) begin
			err_total++;
			tally_and_finish();
		end
	endtask : run
	// split at the 4KB page break
	function automatic logic [63:0] ea(input int i);
		logic [12:0] o;
		o = {1'b0, p1[11:0]} + 13'(4 * i);
		return (o < 13'h1000) ? p1 + 64'(4 * i) : p2 + 64'(o - 13'h1000);
	endfunction : ea
	function automatic logic [31:0] edw(input int k, input int w, input logic [63:0] b);
		logic [63:0] c;
		c = b + 64'(k - 1);
		if (k < 1)
			return 32'h0;
		case (w)
			0: return c[31:0];
			1: return c[63:32];
			2: return {16'h0100 + 16'(k), 16'(k)};
			3: return {5'h0, 3'h7, 8'h3F, 16'h0080 + 16'(k)};
			4: return 32'(k);
			5: return 32'hABCD_0000;
			6: return 32'(k);
			7: return (k == 1) ? 32'h80 : 32'h0;
			default: return 32'h0;
		endcase
	endfunction : edw
	// ==========================================
	// scenarios
	task automatic feat_all;
		logic [7:0] fl[15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
			8'h09, 8'h0A, 8'h0B, 8'h80, 8'h0C, 8'h00, 8'h7F};
		logic ok;
		p1 <= 64'h0000_0001_0000_0FF0;
		p2 <= 64'h0000_0004_0000_0000;
		foreach (fl[j]) begin
			ok = (fl[j] >= 8'h01 && fl[j] <= 8'h0B) || fl[j] == 8'h80;
			run(1'b0, {24'hFF_FFFF, fl[j]});
			chk("fstat", cst, ok ? 64'h0 : 64'h2);
			if (ok)
				chk("dw0", dw0, 32'h1000_0000 | fl[j]);
			chk("persist", pers, fl[j] == 8'h03 || fl[j] == 8'h80);
			chk("fwr", u_host.wa.size(), fl[j] == 8'h03 ? 8 : 0);
			for (int i = 0; i < u_host.wa.size(); i++) begin
				chk("faddr", u_host.wa[i], ea(i));
				chk("fdata", u_host.wd[i], 32'hA5A5_0000 | i);
			end
		end
	endtask : feat_all
	task automatic err_log;
		logic [63:0] b;
		b = 64'h0000_0001_0000_0005;
		chk("count0", ecnt, 64'h1);
		@(posedge i_clk);
		rv <= b;
		rs <= 1'b1;
		@(posedge i_clk);
		rs <= 1'b0;
		for (int k = 1; k <= 2; k++) begin
			@(posedge i_clk);
			ev <= 1'b1;
			sq <= 16'(k);
			ci <= 16'h0100 + 16'(k);
			sc <= 16'h0080 + 16'(k);
			eb <= 8'h3F;
			eo <= 3'h7;
			lba <= {32'hABCD_0000, 32'(k)};
			ns <= 32'(k);
			vl <= (k == 1) ? 8'h80 : 8'h00;
		end
		@(posedge i_clk);
		ev <= 1'b0;
		tick();
		chk("count", ecnt, b + 64'h2);
		p1 <= 64'h0000_0002_0000_0F80;
		p2 <= 64'h0000_0003_0000_0000;
		slow <= 1'b1;
		// reserved top bits set, three entries asked
		run(1'b1, {4'hF, 12'h030, 16'h0001});
		chk("lstat", cst, 64'h0);
		chk("lwr", u_host.wa.size(), 48);
		for (int i = 0; i < u_host.wa.size(); i++) begin
			chk("laddr", u_host.wa[i], ea(i));
			chk("ldata", u_host.wd[i], edw(2 - i / 16, i % 16, b));
		end
	endtask : err_log
	task automatic log_sel;
		logic [15:0] ls[8] = '{16'h0000, 16'h0004, 16'h007F, 16'h0100, 16'h0002, 16'h0003,
			16'h0080, 16'h00FF};
		slow <= 1'b0;
		foreach (ls[j]) begin
			run(1'b1, {4'h0, 12'h004, ls[j]});
			chk("sstat", cst, j < 4 ? 64'h9 : 64'h0);
			chk("swr", u_host.wa.size(), j < 4 ? 0 : 4);
			for (int i = 0; i < u_host.wa.size(); i++)
				chk("sdata", u_host.wd[i], 32'hA5A5_0000 | i);
		end
	endtask : log_sel
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		tick();
		chk("ready", crdy, 64'h1);
		chk("entries", nent, 64'h4);
		feat_all();
		err_log();
		log_sel();
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge i_clk);
		err_total++;
		tally_and_finish();
	end
endmodule : admin_feature_log_query_tb_top
`default_nettype wire
